// [verilog/sdsp_pkg.sv]
// package for the saturating dsp alu: operation codes, constants, carriers
package sdsp_pkg;

	// ************************************************************
	// widths and saturation limits
	// ************************************************************
	localparam int WORD_W = 32;
	localparam int HALF_W = 16;
	localparam logic [31:0] WORD_MAX = 32'h7FFFFFFF;
	localparam logic [31:0] WORD_MIN = 32'h80000000;
	localparam logic [15:0] HALF_MAX = 16'h7FFF;
	localparam logic [15:0] HALF_MIN = 16'h8000;
	localparam logic [31:0] RESULT_RESET = 32'h00000000;
	localparam logic [4:0] DEST_RESET = 5'h00;
	localparam int PIPE_LATENCY = 1;

	// ************************************************************
	// operation selector
	// ************************************************************
	typedef enum logic [2:0] {
		SDSP_OP_ABS = 3'b000,
		SDSP_OP_ADD = 3'b001,
		SDSP_OP_DABS = 3'b010,
		SDSP_OP_DADD = 3'b011,
		SDSP_OP_DMUL = 3'b100,
		SDSP_OP_DSUB = 3'b101
	} sdsp_op_e;

	typedef struct packed {
		logic valid;
		sdsp_op_e op;
		logic guard_en;
		logic [31:0] guard;
		logic [31:0] src_a;
		logic [31:0] src_b;
		logic [4:0] dest;
	} sdsp_req_s;

	typedef struct packed {
		logic wr_en;
		logic [4:0] dest;
		logic [31:0] data;
	} sdsp_rsp_s;

endpackage

// [verilog/sdsp_alu.sv]
// saturating dsp alu: clipped 32-bit ops and dual halfword ops, one register stage
// How it works
// - 32-bit add clamps to 7FFFFFFF or 80000000
// - guard lsb zero suppresses destination write
// - dual abs per half, clamp 0 to 7FFF
// - half 8000 gives 7FFF, never wraps
// - dual add clamps each half 8000..7FFF
// - dual multiply clamps each product 8000..7FFF
// - dual subtract a minus b, clamped per half
// - upper to 31:16, lower to 15:0, no carry
// - halves are sign-extended two's complement
// - 32-bit abs of 80000000 gives 7FFFFFFF
`timescale 1ns/1ps
`default_nettype none
module sdsp_alu
	import sdsp_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire sdsp_req_s req,
	output sdsp_rsp_s rsp
);

	// ************************************************************
	// lane helpers
	// ************************************************************
	function automatic logic [15:0] sat16(input logic signed [32:0] v);
		if (v > 33'sd32767) begin
			return HALF_MAX;
		end else if (v < -33'sd32768) begin
			return HALF_MIN;
		end else begin
			return v[15:0];
		end
	endfunction

	function automatic logic [15:0] lane(input sdsp_op_e op, input logic [15:0] a, input logic [15:0] b);
		logic signed [32:0] sa;
		logic signed [32:0] sb;
		logic signed [32:0] r;
		sa = 33'($signed(a));
		sb = 33'($signed(b));
		r = 33'sd0;
		case (op)
			SDSP_OP_DADD: r = sa + sb;
			SDSP_OP_DMUL: r = 33'(sa * sb);
			SDSP_OP_DSUB: r = sa - sb;
			SDSP_OP_DABS: r = (sb < 0) ? -sb : sb;
			default: r = 33'sd0;
		endcase
		return sat16(r);
	endfunction

	function automatic logic [31:0] sat32(input logic signed [33:0] v);
		if (v > 34'sd2147483647) begin
			return WORD_MAX;
		end else if (v < -34'sd2147483648) begin
			return WORD_MIN;
		end else begin
			return v[31:0];
		end
	endfunction

	// guard bit 0 gates the write; no guard means write whenever valid
	function automatic logic write_allowed(input sdsp_req_s r);
		return r.valid && (!r.guard_en || r.guard[0]);
	endfunction

	// ************************************************************
	// result selection
	// ************************************************************
	logic [1:0][15:0] lane_res;
	logic [31:0] data_d;
	logic wr_en_d;
	logic signed [33:0] wa;
	logic signed [33:0] wb;
	logic wr_en_q;
	logic [4:0] dest_q;
	logic [31:0] data_q;

	// one saturating unit per halfword, no carry between them
	generate
		for (genvar g = 0; g < 2; g++) begin : g_lane
			assign lane_res[g] = lane(req.op, req.src_a[16*g+:16], req.src_b[16*g+:16]);
		end
	endgenerate

	always_comb begin
		wa = 34'($signed(req.src_a));
		wb = 34'($signed(req.src_b));
		case (req.op)
			SDSP_OP_ADD: data_d = sat32(wa + wb);
			SDSP_OP_ABS: data_d = sat32((wb < 0) ? -wb : wb);
			default: data_d = lane_res;
		endcase
	end

	always_comb begin
		wr_en_d = write_allowed(req);
	end

	// ************************************************************
	// output stage, one flop per field
	// ************************************************************
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wr_en_q <= 1'b0;
		end else begin
			wr_en_q <= wr_en_d;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dest_q <= DEST_RESET;
		end else begin
			dest_q <= req.dest;
		end
	end

	// data moves every cycle, so a refused write still shows its result
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			data_q <= RESULT_RESET;
		end else begin
			data_q <= data_d;
		end
	end

	assign rsp = '{wr_en: wr_en_q, dest: dest_q, data: data_q};

	// ************************************************************
	// checks
	// ************************************************************
	AST_GUARD: assert property (@(posedge clk) disable iff (!resetn)
		(req.valid && req.guard_en && !req.guard[0]) |=> !rsp.wr_en)
		else $error("write despite false guard");
	AST_GUARD_ON: assert property (@(posedge clk) disable iff (!resetn)
		(req.valid && (!req.guard_en || req.guard[0])) |=> rsp.wr_en)
		else $error("write missing with true guard");
	// wrapped 32-bit sum, used to spot overflow in the checks
	logic [31:0] sum_wrap;
	assign sum_wrap = req.src_a + req.src_b;
	AST_ADD_POS: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_ADD && !req.src_a[31] && !req.src_b[31] && sum_wrap[31])
		|=> rsp.data == WORD_MAX)
		else $error("positive overflow not clamped");
	AST_ADD_NEG: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_ADD && req.src_a[31] && req.src_b[31] && !sum_wrap[31]) |=> rsp.data == WORD_MIN)
		else $error("negative overflow not clamped");
	AST_ABS_MIN: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_ABS && req.src_b == WORD_MIN) |=> rsp.data == WORD_MAX)
		else $error("abs of min word wrong");
	AST_DABS_MIN: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_DABS && req.src_b[15:0] == HALF_MIN) |=> rsp.data[15:0] == HALF_MAX)
		else $error("dual abs of min half wrong");
	AST_DABS_POS: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_DABS) |=> !rsp.data[31] && !rsp.data[15])
		else $error("dual abs result negative");
	AST_DADD_LANE: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_DADD && req.src_b[15:0] == 16'h0000) |=> rsp.data[15:0] == $past(req.src_a[15:0]))
		else $error("lane carry or mix");
	AST_DSUB_SAT: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_DSUB && req.src_a[31:16] == HALF_MAX && req.src_b[31:16] == HALF_MIN)
		|=> rsp.data[31:16] == HALF_MAX)
		else $error("dual subtract not clamped");
	AST_DMUL_SAT: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_DMUL && req.src_a[15:0] == HALF_MIN && req.src_b[15:0] == HALF_MIN)
		|=> rsp.data[15:0] == HALF_MAX)
		else $error("dual multiply not clamped");
	AST_DADD_SAT: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_DADD && req.src_a[15:0] == HALF_MIN && req.src_b[15:0] == 16'hFFFF)
		|=> rsp.data[15:0] == HALF_MIN)
		else $error("dual add not clamped low");
	AST_ADD_EXACT: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_ADD && (req.src_a[31] != req.src_b[31]))
		|=> rsp.data == $past(sum_wrap))
		else $error("mixed sign add not exact");
	AST_ABS_EXACT: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_ABS && !req.src_b[31])
		|=> rsp.data == $past(req.src_b))
		else $error("abs of positive word changed");
	AST_ABS_NONNEG: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_ABS) |=> !rsp.data[31])
		else $error("abs result negative");
	AST_DABS_HIGH: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_DABS && req.src_b[31:16] == HALF_MIN)
		|=> rsp.data[31:16] == HALF_MAX)
		else $error("dual abs of min upper half wrong");
	AST_DADD_HIGH: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_DADD && req.src_a[31:16] == HALF_MAX && req.src_b[31:16] == 16'h0001)
		|=> rsp.data[31:16] == HALF_MAX)
		else $error("dual add not clamped high");
	AST_DADD_UPPER: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_DADD && req.src_b[31:16] == 16'h0000)
		|=> rsp.data[31:16] == $past(req.src_a[31:16]))
		else $error("upper lane disturbed by lower lane");
	AST_DSUB_LOW: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_DSUB && req.src_a[15:0] == HALF_MIN && req.src_b[15:0] == 16'h0001)
		|=> rsp.data[15:0] == HALF_MIN)
		else $error("dual subtract not clamped low");
	AST_DMUL_NEG: assert property (@(posedge clk) disable iff (!resetn)
		(req.op == SDSP_OP_DMUL && req.src_a[31:16] == HALF_MAX && req.src_b[31:16] == HALF_MIN)
		|=> rsp.data[31:16] == HALF_MIN)
		else $error("dual multiply not clamped low");
	AST_IDLE: assert property (@(posedge clk) disable iff (!resetn)
		!req.valid |=> !rsp.wr_en)
		else $error("write without a request");
	AST_DEST: assert property (@(posedge clk) disable iff (!resetn)
		req.valid |=> rsp.dest == $past(req.dest))
		else $error("destination index not passed on");

	COV_ADD_SAT: cover property (@(posedge clk) disable iff (!resetn)
		req.op == SDSP_OP_ADD ##1 rsp.data == WORD_MAX);
	COV_GUARD_OFF: cover property (@(posedge clk) disable iff (!resetn)
		req.valid && req.guard_en && !req.guard[0]);
	COV_DMUL: cover property (@(posedge clk) disable iff (!resetn)
		req.valid && req.op == SDSP_OP_DMUL ##1 rsp.wr_en);
	COV_DABS_MIN: cover property (@(posedge clk) disable iff (!resetn)
		req.op == SDSP_OP_DABS && req.src_b[15:0] == HALF_MIN);
	COV_DSUB_SAT: cover property (@(posedge clk) disable iff (!resetn)
		req.op == SDSP_OP_DSUB ##1 rsp.data[31:16] == HALF_MAX);

endmodule
`default_nettype wire

// [test/sdsp_issuer.sv]
// issuer model: packs operands into an alu request
`timescale 1ns/1ps
`default_nettype none
module sdsp_issuer
	import sdsp_pkg::*;
(
	input wire sdsp_req_s raw,
	output sdsp_req_s req
);
	always_comb begin
		req = raw;
		// abs ops carry a zero first operand
		if (raw.op == SDSP_OP_DABS || raw.op == SDSP_OP_ABS)
			req.src_a = 32'h00000000;
	end
endmodule
`default_nettype wire

// [test/saturating_dsp_alu_ops_tb.sv]
// bench: edge and random requests against an integer model
`timescale 1ns/1ps
`default_nettype none
module saturating_dsp_alu_ops_tb;
	import sdsp_pkg::*;
	logic clk;
	logic resetn;
	sdsp_req_s raw;
	sdsp_req_s req;
	sdsp_rsp_s rsp;
	sdsp_rsp_s exp_q;
	int err_count;
	int cmp_count;
	int seed;
	sdsp_alu u_sdsp_alu (.clk(clk), .resetn(resetn), .req(req), .rsp(rsp));
	sdsp_issuer u_sdsp_issuer (.raw(raw), .req(req));
	function automatic logic [15:0] s16(int v);
		return v > int'(HALF_MAX) ? HALF_MAX : v < -int'(HALF_MIN) ? HALF_MIN : v[15:0];
	endfunction
	function automatic logic [31:0] s32(longint v);
		return v > longint'(WORD_MAX) ? WORD_MAX : v < -longint'(WORD_MIN) ? WORD_MIN : v[31:0];
	endfunction
	function automatic logic [31:0] model(sdsp_req_s r);
		longint a;
		longint b;
		int x;
		int z;
		logic [31:0] y;
		a = longint'($signed(r.src_a));
		b = longint'($signed(r.src_b));
		y = s32(r.op == SDSP_OP_ABS ? (b < 0 ? -b : b) : a + b);
		for (int k = 0; k < 2; k++) begin
			x = int'($signed(r.src_a[16*k+:16]));
			z = int'($signed(r.src_b[16*k+:16]));
			if (r.op > SDSP_OP_ADD)
				y[16*k+:16] = s16(r.op == SDSP_OP_DABS ? (z < 0 ? -z : z) : r.op == SDSP_OP_DADD ? x + z :
					r.op == SDSP_OP_DMUL ? x * z : x - z);
		end
		return y;
	endfunction
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up;
		$display("errors %0d of %0d checks", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// answer of the previous request is checked while the next one goes in
	task automatic step(sdsp_req_s r);
		@(posedge clk);
		raw <= r;
		#1;
		check("wr_en", 32'(exp_q.wr_en), 32'(rsp.wr_en));
		check("dest", 32'(exp_q.dest), 32'(rsp.dest));
		check("data", exp_q.data, rsp.data);
		exp_q = '{req.valid && (!req.guard_en || req.guard[0]), req.dest, model(req)};
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		sdsp_req_s r;
		static sdsp_op_e ops [15] = '{SDSP_OP_DABS, SDSP_OP_ABS, SDSP_OP_ADD, SDSP_OP_DADD, SDSP_OP_DMUL,
			SDSP_OP_DSUB, SDSP_OP_DABS, SDSP_OP_DADD, SDSP_OP_DADD, SDSP_OP_DADD, SDSP_OP_DSUB, SDSP_OP_DMUL,
			SDSP_OP_ADD, SDSP_OP_ADD, SDSP_OP_ABS};
		static logic [31:0] va [15] = '{32'h00000000, 32'h00000000, 32'h7FFFFFFF, 32'h80000001, 32'h80000002,
			32'h00018001, 32'h00000000, 32'h12340032, 32'h12348000, 32'h7FFF1234, 32'h7FFF8000, 32'h7FFF8000,
			32'h80000000, 32'h00001200, 32'h00000000};
		static logic [31:0] vb [15] = '{32'h80008001, 32'h80000000, 32'h00000001, 32'hFFFF7FFF, 32'h00024000,
			32'h80010002, 32'h00008000, 32'h00010002, 32'h0000FFFF, 32'h00010000, 32'h80000001, 32'h80008000,
			32'hFFFFFFFF, 32'h000000FF, 32'hFFFFFFFF};
		raw = '0;
		resetn = 1'b0;
		exp_q = '0;
		err_count = 0;
		cmp_count = 0;
		seed = 32'heff4;
		repeat (5) @(posedge clk);
		check("reset data", 32'h00000000, rsp.data);
		check("reset wr_en", 32'h00000000, 32'(rsp.wr_en));
		resetn <= 1'b1;
		for (int i = 0; i < 600; i++) begin
			r = ($bits(sdsp_req_s))'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
			r.op = sdsp_op_e'(3'($unsigned($random(seed)) % 6));
			if (i < 15) begin
				r.op = ops[i];
				r.src_a = va[i];
				r.src_b = vb[i];
				r.valid = 1'b1;
				r.guard_en = 1'b0;
			end
			step(r);
		end
		step('0);
		wrap_up();
	end
endmodule
`default_nettype wire
